// >>> inc/adccfg_pkg.sv
/*
  Constants for the converter configuration register bank: register
  offsets, reset values, field positions, mode codes and the oversampling
  table.
  Assumes a single clock domain and an 8-bit register port.
*/
package adccfg_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [3:0] OFS_SAMPLING = 4'h2; // sampling_config
  localparam logic [3:0] OFS_FRONTEND = 4'h3; // frontend_config
  localparam logic [3:0] OFS_CONVOUT = 4'h4; // conversion_output_config

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_SAMPLING = 8'h0c; // Prescale 00, ratio code 0011
  localparam logic [7:0] RST_FRONTEND = 8'h8b; // Bias 10, gain 001, low bits 11
  localparam logic [7:0] RST_CONVOUT = 8'h00; // All features off
  localparam logic [16:0] RST_OSR = 17'd256; // Ratio of the reset code 0011

  // ----------------------------------------------------------------------
  // Field positions (low bit of each field)
  // ----------------------------------------------------------------------
  localparam int POS_PRESCALE = 6; // sampling_config[7:6]
  localparam int POS_OSR = 2; // sampling_config[5:2]
  localparam int POS_BIAS = 6; // frontend_config[7:6]
  localparam int POS_GAIN = 3; // frontend_config[5:3]
  localparam int POS_AUTOZERO = 2; // frontend_config[2]
  localparam int POS_CONVMODE = 6; // conversion_output_config[7:6]
  localparam int POS_FORMAT = 4; // conversion_output_config[5:4]
  localparam int POS_CRCPAD = 3;
  localparam int POS_RDCRC = 2;
  localparam int POS_OFFCORR = 1;
  localparam int POS_GAINCORR = 0;

  // ----------------------------------------------------------------------
  // Mode codes
  // ----------------------------------------------------------------------
  localparam logic [1:0] CMODE_CONT = 2'h3; // Continuous
  localparam logic [1:0] CMODE_ONE_STBY = 2'h2; // One-shot then standby
  localparam logic [1:0] OPMODE_STANDBY = 2'h2;
  localparam logic [1:0] OPMODE_SHUTDOWN = 2'h0;
  localparam logic [1:0] FMT_TAGGED = 2'h3;
  localparam logic [1:0] FMT_SIGNEXT = 2'h2;
  localparam logic [1:0] FMT_LEFT = 2'h1;

  // ----------------------------------------------------------------------
  // Oversampling ratios, indexed by code
  // ----------------------------------------------------------------------
  localparam logic [16:0] OSR_TABLE [16] = '{
    17'd32, 17'd64, 17'd128, 17'd256, 17'd512, 17'd1024, 17'd2048, 17'd4096,
    17'd8192, 17'd16384, 17'd20480, 17'd24576, 17'd40960, 17'd49152,
    17'd81920, 17'd98304};

  // Widest prescale division minus one
  localparam logic [2:0] DIV_MAX = 3'h7;

endpackage

// >>> verilog/adccfg_format.sv
/*
  Result formatter: saturates a corrected result and packs it into the
  output word chosen by the format field. Pure combinational logic.
  Assumes the caller registers the output.
*/
`timescale 1ns/1ps
module adccfg_format #(
  parameter int CORR_W = 20,
  parameter int TAG_W = 4
) (
  input wire logic signed [CORR_W-1:0] corr_val,
  input wire logic [TAG_W-1:0] tag,
  input wire logic [1:0] fmt,
  output logic [31:0] word
);

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  if (CORR_W < 17) begin : g_bad_w
    $error("adccfg_format: CORR_W must be at least 17");
  end
  if (TAG_W != 4) begin : g_bad_tag
    $error("adccfg_format: TAG_W must be 4");
  end

  localparam logic signed [CORR_W-1:0] MAX17 = CORR_W'(65535);
  localparam logic signed [CORR_W-1:0] MIN17 = -CORR_W'(65536);
  localparam logic signed [CORR_W-1:0] MAX16 = CORR_W'(32767);
  localparam logic signed [CORR_W-1:0] MIN16 = -CORR_W'(32768);

  // Saturated copies, 17-bit for overrange formats, 16-bit otherwise
  logic [16:0] sat17;
  logic [15:0] sat16;

  // ----------------------------------------------------------------------
  // Saturation and packing
  // ----------------------------------------------------------------------
  always_comb begin
    // Overrange formats keep one extra bit of headroom
    if (corr_val > MAX17) begin
      sat17 = 17'h0ffff;
    end else if (corr_val < MIN17) begin
      sat17 = 17'h10000;
    end else begin
      sat17 = corr_val[16:0];
    end
    // Plain formats lock at the code limits
    if (corr_val > MAX16) begin
      sat16 = 16'h7fff;
    end else if (corr_val < MIN16) begin
      sat16 = 16'h8000;
    end else begin
      sat16 = corr_val[15:0];
    end
    case (fmt)
      adccfg_pkg::FMT_TAGGED: begin
        word = {tag, {12{sat17[16]}}, sat17[15:0]};
      end
      adccfg_pkg::FMT_SIGNEXT: begin
        word = {{16{sat17[16]}}, sat17[15:0]};
      end
      adccfg_pkg::FMT_LEFT: begin
        word = {sat16, 16'h0000};
      end
      default: begin
        word = {16'h0000, sat16};
      end
    endcase
  end

endmodule

// >>> verilog/adccfg_regs.sv
/*
  Configuration register bank of a delta-sigma converter: three 8-bit
  registers, the analog clock prescaler, oversampling ratio lookup,
  end-of-conversion mode change, digital correction and result formatting.
  Assumes a serial front end that decodes commands into single-cycle
  register reads and writes, and a modulator/decimator that reports each
  finished conversion or sequence cycle with a one-cycle pulse.
*/
`timescale 1ns/1ps
// Functional notes
// - Prescale code divides analog clock by 1/2/4/8
// - Ratio code selects 32 up to 98304
// - Bias code scales channel current
// - Autozero bit enables input auto-zeroing
// - Mode 11 converts or sequences continuously
// - Mode 10 one-shot then operating mode standby
// - Mode 0x one-shot then operating mode shutdown
// - Format 11: tag, 12 sign, 16 data
// - Format 10: 16 sign, 16 data
// - Format 01: data then zeros, saturating
// - Format 00: bare saturating 16-bit code
// - Pad bit: CRC plus sixteen zeros
// - Read CRC enable appends checksum
// - Offset enable applies stored offset
// - Operating mode: 11 convert, 10 standby
// - Result holds corrected, formatted data
module adccfg_regs #(
  parameter int GAIN_FRAC = 15,
  parameter int TAG_W = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  // Register port from the serial front end
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Conversion engine
  input wire logic conv_done,
  input wire logic raw_valid,
  input wire logic signed [16:0] raw_result,
  input wire logic [TAG_W-1:0] raw_tag,
  input wire logic signed [15:0] offset_cal,
  input wire logic [15:0] gain_cal,
  // Configuration outputs
  output logic analog_master_clock_en,
  output logic [16:0] oversample_ratio,
  output logic [1:0] bias_current_sel,
  output logic [2:0] gain_sel,
  output logic input_autozero_en,
  output logic continuous_mode,
  output logic read_crc_en,
  output logic crc_pad_sel,
  // Operating mode update request
  output logic opmode_wr,
  output logic [1:0] opmode_val,
  // Formatted result
  output logic [31:0] conversion_result,
  output logic result_valid
);

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  if (GAIN_FRAC < 1 || GAIN_FRAC > 15) begin : g_bad_frac
    $error("adccfg_regs: GAIN_FRAC must lie in 1..15");
  end

  localparam int CORR_W = 20;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] sampling;
    logic [7:0] frontend;
    logic [7:0] convout;
    logic [7:0] rdata;
    logic rvalid;
    logic [2:0] div_cnt;
    logic analog_master_clock_en;
    logic [16:0] oversample_ratio_sel;
    logic opmode_wr;
    logic [1:0] opmode_val;
    logic [31:0] result;
    logic result_valid;
  } adccfg_state_t;

  adccfg_state_t st_r; // Registered state
  adccfg_state_t st_nxt; // Next state

  // Corrected result and its packed form
  logic signed [CORR_W-1:0] corr_val;
  logic signed [34:0] gain_prod;
  logic [31:0] fmt_word;
  logic [2:0] div_last;

  // ----------------------------------------------------------------------
  // Digital correction
  // ----------------------------------------------------------------------
  // Offset first, then gain; the gain word is unsigned with GAIN_FRAC
  // fractional bits, so a value of one is 1 << GAIN_FRAC.
  always_comb begin
    logic signed [17:0] with_off;
    with_off = 18'(raw_result);
    if (st_r.convout[adccfg_pkg::POS_OFFCORR]) begin
      // Both terms widened first so the sum cannot wrap
      with_off = 18'(raw_result) + 18'(offset_cal);
    end
    gain_prod = 35'(with_off) * 35'($signed({1'b0, gain_cal}));
    if (st_r.convout[adccfg_pkg::POS_GAINCORR]) begin
      corr_val = CORR_W'(gain_prod >>> GAIN_FRAC);
    end else begin
      corr_val = CORR_W'(with_off);
    end
  end

  adccfg_format #(
    .CORR_W(CORR_W),
    .TAG_W(TAG_W)
  ) u_format (
    .corr_val(corr_val),
    .tag(raw_tag),
    .fmt(st_r.convout[adccfg_pkg::POS_FORMAT +: 2]),
    .word(fmt_word)
  );

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.rvalid = 1'b0;
    st_nxt.opmode_wr = 1'b0;
    st_nxt.result_valid = 1'b0;

    // Register writes; reserved low bits are stored as written, so a host
    // that breaks the fill convention reads back what it wrote.
    if (reg_wr) begin
      if (reg_addr == adccfg_pkg::OFS_SAMPLING) begin
        st_nxt.sampling = reg_wdata;
      end else if (reg_addr == adccfg_pkg::OFS_FRONTEND) begin
        st_nxt.frontend = reg_wdata;
      end else if (reg_addr == adccfg_pkg::OFS_CONVOUT) begin
        st_nxt.convout = reg_wdata;
      end
    end

    // Register reads answer one cycle later; unmapped offsets read zero
    if (reg_rd) begin
      st_nxt.rvalid = 1'b1;
      if (reg_addr == adccfg_pkg::OFS_SAMPLING) begin
        st_nxt.rdata = st_r.sampling;
      end else if (reg_addr == adccfg_pkg::OFS_FRONTEND) begin
        st_nxt.rdata = st_r.frontend;
      end else if (reg_addr == adccfg_pkg::OFS_CONVOUT) begin
        st_nxt.rdata = st_r.convout;
      end else begin
        st_nxt.rdata = 8'h00;
      end
    end

    // Prescaler: enable pulse once per division period
    if (st_r.div_cnt >= div_last) begin
      st_nxt.div_cnt = 3'h0;
      st_nxt.analog_master_clock_en = 1'b1;
    end else begin
      st_nxt.div_cnt = st_r.div_cnt + 3'h1;
      st_nxt.analog_master_clock_en = 1'b0;
    end

    // Ratio lookup, registered to keep the table off the output path
    st_nxt.oversample_ratio_sel = adccfg_pkg::OSR_TABLE[st_r.sampling[adccfg_pkg::POS_OSR +: 4]];

    // End of a single conversion or sequence cycle
    if (conv_done) begin
      case (st_r.convout[adccfg_pkg::POS_CONVMODE +: 2])
        adccfg_pkg::CMODE_CONT: begin
          st_nxt.opmode_wr = 1'b0;
        end
        adccfg_pkg::CMODE_ONE_STBY: begin
          st_nxt.opmode_wr = 1'b1;
          st_nxt.opmode_val = adccfg_pkg::OPMODE_STANDBY;
        end
        default: begin
          st_nxt.opmode_wr = 1'b1;
          st_nxt.opmode_val = adccfg_pkg::OPMODE_SHUTDOWN;
        end
      endcase
    end

    // Capture each new result in the selected format
    if (raw_valid) begin
      st_nxt.result = fmt_word;
      st_nxt.result_valid = 1'b1;
    end
  end

  // Division period minus one, from the prescale code
  always_comb begin
    case (st_r.sampling[adccfg_pkg::POS_PRESCALE +: 2])
      2'h3: div_last = adccfg_pkg::DIV_MAX;
      2'h2: div_last = 3'h3;
      2'h1: div_last = 3'h1;
      default: div_last = 3'h0;
    endcase
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '{
        sampling: adccfg_pkg::RST_SAMPLING,
        frontend: adccfg_pkg::RST_FRONTEND,
        convout: adccfg_pkg::RST_CONVOUT,
        rdata: 8'h00,
        rvalid: 1'b0,
        div_cnt: 3'h0,
        analog_master_clock_en: 1'b0,
        oversample_ratio_sel: adccfg_pkg::RST_OSR,
        opmode_wr: 1'b0,
        opmode_val: 2'h0,
        result: 32'h0000_0000,
        result_valid: 1'b0
      };
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs, all from the state register, continuous_mode through a mode compare
  // ----------------------------------------------------------------------
  assign reg_rdata = st_r.rdata;
  assign reg_rvalid = st_r.rvalid;
  assign analog_master_clock_en = st_r.analog_master_clock_en;
  assign oversample_ratio = st_r.oversample_ratio_sel;
  assign bias_current_sel = st_r.frontend[adccfg_pkg::POS_BIAS +: 2];
  assign gain_sel = st_r.frontend[adccfg_pkg::POS_GAIN +: 3];
  assign input_autozero_en = st_r.frontend[adccfg_pkg::POS_AUTOZERO];
  assign continuous_mode = (st_r.convout[adccfg_pkg::POS_CONVMODE +: 2]
                            == adccfg_pkg::CMODE_CONT);
  // Checksum settings steer only the read path, never the config checksum
  assign read_crc_en = st_r.convout[adccfg_pkg::POS_RDCRC];
  assign crc_pad_sel = st_r.convout[adccfg_pkg::POS_CRCPAD];
  assign opmode_wr = st_r.opmode_wr;
  assign opmode_val = st_r.opmode_val;
  assign conversion_result = st_r.result;
  assign result_valid = st_r.result_valid;

endmodule

// >>> dv/adccfg_host.sv
/*
  Behavioural serial host: turns register reads and writes into strobes.
  Assumes one access at a time, launched on the falling clock edge.
*/
`timescale 1ns/1ps
module adccfg_host (
  input wire logic clk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [3:0] reg_addr,
  output logic [7:0] reg_wdata
);
  // ----------------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------------
  // Idle bus at time zero
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
  end

  // Write; the reserved low bits are patched, so the caller sees what went out
  task automatic wr(input logic [3:0] a, inout logic [7:0] d);
    if (a == 4'h2) d[1:0] = 2'h0;
    if (a == 4'h3) d[1:0] = 2'h3;
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
    // Released lines show garbage, never the old value
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask

  // Read; the answer is picked up by the bench monitor
  task automatic rd(input logic [3:0] a);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
  endtask
endmodule

// >>> dv/adccfg_regs_sva.sv
/*
  Checker for the configuration bank: read answers, field outputs after
  writes, end-of-conversion mode requests and result strobes.
  Assumes writes at least two cycles apart, as the host gives them.
*/
`timescale 1ns/1ps
module adccfg_regs_sva (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic conv_done,
  input wire logic raw_valid,
  input wire logic [1:0] bias_current_sel,
  input wire logic [2:0] gain_sel,
  input wire logic input_autozero_en,
  input wire logic continuous_mode,
  input wire logic read_crc_en,
  input wire logic crc_pad_sel,
  input wire logic opmode_wr,
  input wire logic [1:0] opmode_val,
  input wire logic result_valid
);
  // ----------------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Write to the front-end register
  sequence s_wr_fe;
    reg_wr && reg_addr == adccfg_pkg::OFS_FRONTEND;
  endsequence
  // Write to the conversion/output register
  sequence s_wr_co;
    reg_wr && reg_addr == adccfg_pkg::OFS_CONVOUT;
  endsequence
  // End of a one-shot conversion
  sequence s_one_shot;
    conv_done && !continuous_mode;
  endsequence

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  AST_RD_ANSWER: assert property (
    reg_rd |=> reg_rvalid) else $error("read answer missing");
  AST_RD_UNMAPPED: assert property (
    reg_rd && !(reg_addr inside {4'h2, 4'h3, 4'h4}) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_BIAS: assert property (
    s_wr_fe |-> ##2 bias_current_sel == $past(reg_wdata[7:6], 2))
    else $error("bias field wrong");
  AST_GAIN: assert property (
    s_wr_fe |-> ##2 gain_sel == $past(reg_wdata[5:3], 2)) else $error("gain field wrong");
  AST_AUTOZERO: assert property (
    s_wr_fe |-> ##2 input_autozero_en == $past(reg_wdata[2], 2))
    else $error("autozero wrong");
  AST_CRC: assert property (
    s_wr_co |-> ##2 {crc_pad_sel, read_crc_en} == $past(reg_wdata[3:2], 2))
    else $error("crc bits wrong");
  AST_CONT: assert property (
    s_wr_co |-> ##2 continuous_mode == ($past(reg_wdata[7:6], 2) == adccfg_pkg::CMODE_CONT))
    else $error("continuous level wrong");
  AST_NO_REQ: assert property (
    conv_done && continuous_mode |=> !opmode_wr) else $error("mode request in continuous");
  AST_REQ: assert property (
    s_one_shot |=> opmode_wr && !opmode_val[0]) else $error("mode request missing");
  AST_REQ_CAUSE: assert property (
    opmode_wr |-> $past(conv_done)) else $error("mode request without cause");
  AST_RESULT: assert property (
    raw_valid |=> result_valid) else $error("result strobe missing");
endmodule

bind adccfg_regs adccfg_regs_sva u_sva (
  .clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .conv_done(conv_done), .raw_valid(raw_valid), .bias_current_sel(bias_current_sel),
  .gain_sel(gain_sel), .input_autozero_en(input_autozero_en),
  .continuous_mode(continuous_mode), .read_crc_en(read_crc_en), .crc_pad_sel(crc_pad_sel),
  .opmode_wr(opmode_wr), .opmode_val(opmode_val), .result_valid(result_valid)
);

// >>> dv/adccfg_regs_tb.sv
/*
  Self-checking bench for the configuration bank.
  Assumes the host model drives the register port; results are queued.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin \
  samples_checked++; \
  if ((g) !== (e)) begin \
    n_fail++; \
    $display("wrong value at %0t: got %h exp %h", $time, g, e); \
  end \
end
module adccfg_regs_tb;
  localparam int GF = 15;
  logic clk, rst_n, conv_done, raw_valid, reg_wr, reg_rd, reg_rvalid, analog_master_clock_en;
  logic input_autozero_en, continuous_mode, read_crc_en, crc_pad_sel, opmode_wr, result_valid;
  logic [3:0] reg_addr, raw_tag;
  logic [7:0] reg_wdata, reg_rdata;
  logic signed [16:0] raw_result;
  logic signed [15:0] offset_cal;
  logic [15:0] gain_cal;
  logic [16:0] oversample_ratio;
  logic [1:0] bias_current_sel, opmode_val;
  logic [2:0] gain_sel;
  logic [31:0] conversion_result;
  logic [7:0] sh [2:4]; // Shadow of the three registers
  logic [7:0] q_rd [$];
  logic [31:0] q_res [$];
  logic [1:0] q_op [$];
  int n_fail = 0;
  int samples_checked = 0;
  int oversample_ratio_sel [16] = '{32, 64, 128, 256, 512, 1024, 2048, 4096, 8192, 16384, 20480, 24576,
    40960, 49152, 81920, 98304};
  int cnt;
  logic [31:0] e_mon; // Oldest note, popped once so the macro never pops twice

  adccfg_host host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata));
  adccfg_regs #(.GAIN_FRAC(GF), .TAG_W(4)) dut (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .conv_done(conv_done), .raw_valid(raw_valid),
    .raw_result(raw_result), .raw_tag(raw_tag), .offset_cal(offset_cal), .gain_cal(gain_cal),
    .analog_master_clock_en(analog_master_clock_en), .oversample_ratio(oversample_ratio),
    .bias_current_sel(bias_current_sel), .gain_sel(gain_sel),
    .input_autozero_en(input_autozero_en), .continuous_mode(continuous_mode),
    .read_crc_en(read_crc_en), .crc_pad_sel(crc_pad_sel), .opmode_wr(opmode_wr),
    .opmode_val(opmode_val), .conversion_result(conversion_result),
    .result_valid(result_valid));

  // ----------------------------------------------------------------------
  // Clock, watchdog, verdict
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // A hang counts as a failure
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    results();
  end
  task automatic results;
    if (n_fail == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Monitor: each answer takes the oldest note; a stray answer meets X
  // ----------------------------------------------------------------------
  always @(negedge clk) begin
    if (reg_rvalid === 1'b1) begin
      e_mon = q_rd.size() ? {24'h000000, q_rd.pop_front()} : 'x;
      `CHK(reg_rdata, e_mon)
    end
    if (result_valid === 1'b1) begin
      e_mon = q_res.size() ? q_res.pop_front() : 'x;
      `CHK(conversion_result, e_mon)
    end
    if (opmode_wr === 1'b1) begin
      e_mon = q_op.size() ? {30'h00000000, q_op.pop_front()} : 'x;
      `CHK(opmode_val, e_mon)
    end
  end

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Expected word; 16-bit formats clamp to signed code limits, 32-bit ones to 17 bits
  function automatic logic [31:0] fmtw(input logic [1:0] f, input int v, input logic [3:0] t);
    logic [15:0] s;
    logic [16:0] w;
    s = v > 32767 ? 16'h7fff : v < -32768 ? 16'h8000 : 16'(v);
    w = v > 65535 ? 17'h0ffff : v < -65536 ? 17'h10000 : 17'(v);
    case (f)
      2'h0: fmtw = {16'h0000, s};
      2'h1: fmtw = {s, 16'h0000};
      2'h2: fmtw = {{15{w[16]}}, w};
      default: fmtw = {t, {11{w[16]}}, w};
    endcase
  endfunction
  // Field outputs against the shadow; ratio needs two cycles
  task automatic chk_fields;
    repeat (2) @(negedge clk);
    `CHK(bias_current_sel, sh[3][7:6])
    `CHK(gain_sel, sh[3][5:3])
    `CHK(input_autozero_en, sh[3][2])
    `CHK(continuous_mode, sh[4][7:6] == 2'h3)
    `CHK({crc_pad_sel, read_crc_en}, sh[4][3:2])
    `CHK(oversample_ratio, 17'(oversample_ratio_sel[sh[2][5:2]]))
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    host.wr(a, d);
    if (a inside {4'h2, 4'h3, 4'h4}) sh[a] = d;
    chk_fields();
  endtask
  task automatic rreg(input logic [3:0] a);
    q_rd.push_back(a inside {4'h2, 4'h3, 4'h4} ? sh[a] : 8'h00);
    host.rd(a);
  endtask
  // One raw result with random calibration values
  task automatic conv(input logic [1:0] f, input logic [1:0] en);
    int v;
    logic [16:0] r;
    logic [3:0] t;
    logic [15:0] o;
    logic [15:0] g;
    r = 17'($urandom);
    t = 4'($urandom);
    o = 16'($urandom);
    g = 16'($urandom);
    v = int'($signed(r)) + (en[1] ? int'($signed(o)) : 0);
    if (en[0]) v = int'((longint'(v) * longint'(g)) >>> GF);
    q_res.push_back(fmtw(f, v, t));
    @(negedge clk);
    raw_valid = 1'b1;
    raw_result = r;
    raw_tag = t;
    offset_cal = o;
    gain_cal = g;
    @(negedge clk);
    raw_valid = 1'b0;
    raw_result = ~r;
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    {rst_n, conv_done, raw_valid, raw_result, raw_tag, offset_cal, gain_cal} = '0;
    sh[2] = 8'h0c;
    sh[3] = 8'h8b;
    sh[4] = 8'h00;
    void'($urandom(10474));
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    chk_fields();
    // Reset values and unmapped places
    for (int a = 0; a < 6; a++) rreg(4'(a));
    wreg(4'h9, 8'h5a);
    rreg(4'h9);
    repeat (12) begin
      cnt = 2 + $urandom % 3;
      wreg(4'(cnt), 8'($urandom));
      rreg(4'(cnt));
    end
    for (int c = 0; c < 16; c++) wreg(4'h2, {2'h0, 4'(c), 2'h3});
    // Prescaler: pulses in a 32-cycle window
    for (int c = 0; c < 4; c++) begin
      wreg(4'h2, {2'(c), 4'h3, 2'h0});
      cnt = 0;
      repeat (32) @(negedge clk) cnt += (analog_master_clock_en === 1'b1);
      `CHK(cnt, 32 >> c)
    end
    // End-of-conversion mode requests for every mode code
    for (int m = 0; m < 4; m++) begin
      wreg(4'h4, {2'(m), 6'h00});
      if (m != 3) q_op.push_back(m == 2 ? 2'h2 : 2'h0);
      @(negedge clk);
      conv_done = 1'b1;
      @(negedge clk);
      conv_done = 1'b0;
      repeat (3) @(negedge clk);
    end
    // Every format with every correction combination
    for (int f = 0; f < 4; f++)
      for (int e = 0; e < 4; e++) begin
        wreg(4'h4, {2'h3, 2'(f), 2'h0, 2'(e)});
        repeat (2) conv(2'(f), 2'(e));
      end
    repeat (5) @(negedge clk);
    `CHK(q_rd.size() + q_res.size() + q_op.size(), 0)
    results();
  end
endmodule
